// >>> core/mmd_decoder.sv
// memory map decoder: routes each master's request to a memory target
// assumes requests are synchronous and held while stalled
`timescale 1ns/100ps
`default_nettype none
module mmd_decoder #(
  parameter int NUM_M = mmd_pkg::NUM_MASTERS
) (
  input  wire logic                    clock,
  input  wire logic                    resetn,
  input  wire logic                    clk_en,
  input  wire logic                    set_rom_unmap,
  input  wire logic                    clr_rom_unmap,
  input  wire logic                    soft_reset,
  input  wire mmd_pkg::mmd_req_t [NUM_M-1:0] req,
  output var  mmd_pkg::mmd_rsp_t [NUM_M-1:0] rsp,
  output logic                         rom_unmap_bit,
  output logic [3:0]                   ext_space_select_pin
);
  typedef struct packed {
    logic                              unmap;
    mmd_pkg::mmd_rsp_t [NUM_M-1:0]     rsp;
    logic [3:0]                        cs;
  } mmd_state_t;

  mmd_state_t state_reg;
  mmd_state_t state_next;

  // decode one memory access for a master, no arbitration
  function automatic mmd_pkg::mmd_rsp_t dec_mem(
    input logic [2:0]  mid,
    input logic [23:0] a,
    input logic        unmap);
    mmd_pkg::mmd_rsp_t r;
    logic ext_ok;
    r = '0;
    r.target = mmd_pkg::MMD_T_RSV;
    ext_ok = (mid == mmd_pkg::M_CORE) || (mid == mmd_pkg::M_DMA3) ||
             (mid > mmd_pkg::M_DMA3);
    if (a < mmd_pkg::CREG_END) begin
      r.target = mmd_pkg::MMD_T_CREG;
    end else if (a < mmd_pkg::DPR_END) begin
      r.target = (mid >= mmd_pkg::M_LCD) ? mmd_pkg::MMD_T_DENY
                                          : mmd_pkg::MMD_T_DPR;
      r.block = {3'h0, a[15:13]};
    end else if (a < mmd_pkg::SPR_END) begin
      r.target = mmd_pkg::MMD_T_SPR;
      r.block = 6'(a[18:13] - 6'h08);
    end else if (a >= mmd_pkg::EXT2_BASE) begin
      r.target = mmd_pkg::MMD_T_EXT;
      if (a >= mmd_pkg::ROM_BASE && !unmap) begin
        r.target = mmd_pkg::MMD_T_ROM;
        r.block = {4'h0, a[16:15]};
      end else if (a >= mmd_pkg::EXT5_BASE) begin
        r.cs = 4'h8;
      end else if (a >= mmd_pkg::EXT4_BASE) begin
        r.cs = 4'h4;
      end else if (a >= mmd_pkg::EXT3_BASE) begin
        r.cs = 4'h2;
      end else begin
        r.cs = 4'h1;
      end
      if (r.target == mmd_pkg::MMD_T_EXT && !ext_ok) begin
        r.target = mmd_pkg::MMD_T_DENY;
        r.cs = 4'h0;
      end
    end
    return r;
  endfunction

  // decode one I/O access to a peripheral group
  function automatic mmd_pkg::mmd_rsp_t dec_io(
    input logic [2:0]  mid,
    input logic [15:0] a);
    mmd_pkg::mmd_rsp_t r;
    r = '0;
    r.target = mmd_pkg::MMD_T_RSV;
    for (int i = 0; i < mmd_pkg::NUM_IO; i++) begin
      if (a >= mmd_pkg::IO_LO[i] && a <= mmd_pkg::IO_HI[i]) begin
        r.target = mmd_pkg::MMD_T_CREG;
        r.block = 6'(i);
        if (mid >= mmd_pkg::M_LCD ||
            (mid != mmd_pkg::M_CORE && !mmd_pkg::IO_DMA_OK[i])) begin
          r.target = mmd_pkg::MMD_T_DENY;
        end
      end
    end
    return r;
  endfunction

  // decode all masters, then grant single-port blocks by fixed priority
  always_comb begin
    logic [31:0] spr_busy;
    mmd_pkg::mmd_rsp_t r;
    spr_busy = '0;
    r = '0;
    state_next = state_reg;
    state_next.cs = 4'h0;
    // hardware reset or clr_rom_unmap clears (set_rom_unmap wins), soft_reset is ignored here
    if (set_rom_unmap) begin
      state_next.unmap = 1'b1;
    end else if (clr_rom_unmap) begin
      state_next.unmap = 1'b0;
    end
    for (int m = 0; m < NUM_M; m++) begin
      r = '0;
      r.target = mmd_pkg::MMD_T_NONE;
      if (req[m].valid) begin
        if (req[m].io) begin
          r = dec_io(3'(m), req[m].addr[15:0]);
        end else begin
          r = dec_mem(3'(m), req[m].addr, state_reg.unmap);
        end
        r.grant = 1'b1;
        if (r.target == mmd_pkg::MMD_T_SPR) begin
          if (spr_busy[r.block[4:0]]) begin
            r.grant = 1'b0;
          end
          spr_busy[r.block[4:0]] = 1'b1;
        end
        if (r.grant) begin
          state_next.cs = state_next.cs | r.cs;
        end
      end
      state_next.rsp[m] = r;
    end
  end

  // state register with synchronous reset and clock enable
  always_ff @(posedge clock) begin
    if (!resetn) begin
      state_reg <= '0;
      state_reg.unmap <= mmd_pkg::ROM_UNMAP_RST;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign rsp                  = state_reg.rsp;
  assign rom_unmap_bit        = state_reg.unmap;
  assign ext_space_select_pin = state_reg.cs;
endmodule
`default_nettype wire

// >>> pkg/mmd_pkg.sv
// package for the memory map decoder: address ranges, master ids, carriers
// assumes byte addresses of 24 bits and I/O word addresses of 16 bits
//
// Contract
// - ROM bit clear: FE0000h..FFFFFFh goes to internal ROM.
// - ROM bit set: top range goes to fourth external space instead.
// - hardware reset clears the ROM bit.
// - software reset instruction leaves the ROM bit unchanged.
// - ROM is four 16K-word blocks, one word per cycle each; the decoder grants all ROM accesses without stalling.
// - external spaces at 800000h (4M), C00000h (2M), E00000h (1M).
// - fourth external space from F00000h, 1M minus 128K, plus ROM if unmapped.
// - chip select of an external space asserts on access to it.
// - lowest 192 bytes are core mapped registers; dual-port RAM above.
// - eight dual-port RAM blocks of 4K words, two accesses per cycle; the decoder grants all accesses to a block without stalling.
// - thirty-two single-port RAM blocks of 4K words, one access per cycle.
// - only DMA controller 3 reaches external memory; the decoder also lets core, LCD and USB requests through.
// - USB and LCD masters cannot reach dual-port RAM.
// - requests come from core, four DMA, LCD and USB masters.
// - unified 16M byte memory space.
// - separate 64K I/O space for peripheral and system registers.
// - I/O word addresses decode to peripheral register groups.
// - some DMA controllers reach listed peripheral I/O registers.
package mmd_pkg;
  localparam int NUM_MASTERS = 7;
  localparam int ADDR_W      = 24;
  localparam int IO_W        = 16;

  // master ids
  localparam logic [2:0] M_CORE = 3'h0;
  localparam logic [2:0] M_DMA0 = 3'h1;
  localparam logic [2:0] M_DMA3 = 3'h4;
  localparam logic [2:0] M_LCD  = 3'h5;
  localparam logic [2:0] M_USB  = 3'h6;

  // memory map boundaries
  localparam logic [23:0] CREG_END  = 24'h0000C0;
  localparam logic [23:0] DPR_END   = 24'h010000;
  localparam logic [23:0] SPR_END   = 24'h050000;
  localparam logic [23:0] EXT2_BASE = 24'h800000;
  localparam logic [23:0] EXT3_BASE = 24'hC00000;
  localparam logic [23:0] EXT4_BASE = 24'hE00000;
  localparam logic [23:0] EXT5_BASE = 24'hF00000;
  localparam logic [23:0] ROM_BASE  = 24'hFE0000;
  localparam int          BLK_SHIFT = 13;  // 4K words = 8K bytes
  localparam int          ROM_SHIFT = 15;  // 16K words = 32K bytes

  // I/O peripheral groups, start and last word address
  localparam int NUM_IO = 12;
  localparam logic [15:0] IO_LO [NUM_IO] = '{
    16'h0000, 16'h0C00, 16'h0D00, 16'h0E00, 16'h0F00, 16'h1000,
    16'h1800, 16'h1840, 16'h1880, 16'h1900, 16'h1A00, 16'h1C00};
  localparam logic [15:0] IO_HI [NUM_IO] = '{
    16'h0004, 16'h0C7F, 16'h0D7F, 16'h0E7F, 16'h0F7F, 16'h10DD,
    16'h181F, 16'h185F, 16'h189F, 16'h197F, 16'h1A6C, 16'h1CFF};
  // groups a DMA may reach (I/O of listed peripherals among these)
  localparam logic [NUM_IO-1:0] IO_DMA_OK = 12'h420;
  // reset value of the rom unmap bit
  localparam logic ROM_UNMAP_RST = 1'b0;

  typedef enum logic [7:0] {
    MMD_T_NONE = 8'h01, MMD_T_CREG = 8'h02, MMD_T_DPR = 8'h04,
    MMD_T_SPR  = 8'h08, MMD_T_ROM = 8'h10, MMD_T_EXT = 8'h20,
    MMD_T_RSV  = 8'h40, MMD_T_DENY = 8'h80
  } mmd_target_t;

  typedef struct packed {
    logic        valid;
    logic        io;
    logic [23:0] addr;
  } mmd_req_t;

  typedef struct packed {
    logic        grant;
    mmd_target_t target;
    logic [5:0]  block;  // ram/rom block or I/O group index
    logic [3:0]  cs;     // external selects 2..5
  } mmd_rsp_t;
endpackage

// >>> tb/mmd_master_model.sv
// master model: one requester facing the decoder
// assumes the bench raises go for one cycle per request
`timescale 1ns/100ps
`default_nettype none
module mmd_master_model (
  input  wire logic              go,
  input  wire logic              io,
  input  wire logic [23:0]       addr,
  output wire mmd_pkg::mmd_req_t req
);
  // released address shows the inverse, never a stale copy; traffic is
  // post-boot, so the last single-port block is free to use
  assign req = '{valid: go, io: io,
                 addr: go ? addr : ~addr};
endmodule
`default_nettype wire

// >>> tb/mmd_props.sv
// checker for the decoder ports
// assumes one clock and a synchronous active low reset
`timescale 1ns/100ps
`default_nettype none
module mmd_props #(parameter int NUM_M = 7) (
  input wire logic                          clock,
  input wire logic                          resetn,
  input wire logic                          clk_en,
  input wire logic                          set_rom_unmap,
  input wire logic                          clr_rom_unmap,
  input wire logic                          soft_reset,
  input wire mmd_pkg::mmd_req_t [NUM_M-1:0] req,
  input wire mmd_pkg::mmd_rsp_t [NUM_M-1:0] rsp,
  input wire logic                          rom_unmap_bit,
  input wire logic [3:0]                    ext_space_select_pin
);
  // memory requests taken this edge
  wire logic [23:0] a0 = req[0].addr;
  wire logic v0 = clk_en && req[0].valid && !req[0].io;
  wire logic v1 = clk_en && req[1].valid && !req[1].io;
  wire logic v5 = clk_en && req[5].valid && !req[5].io;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_rom_mapped: assert property (v0 && a0 >= 24'hFE0000 && !rom_unmap_bit
    |=> rsp[0].target == mmd_pkg::MMD_T_ROM) else $error("rom not hit");
  a_rom_unmapped: assert property (v0 && a0 >= 24'hFE0000 && rom_unmap_bit
    |=> rsp[0].cs == 4'h8) else $error("top not external");
  a_hw_clear: assert property (disable iff (1'b0) !resetn
    |=> !rom_unmap_bit) else $error("unmap kept over reset");
  a_bit_kept: assert property (resetn && !(clk_en && (set_rom_unmap ||
    clr_rom_unmap)) |=> $stable(rom_unmap_bit)) else $error("unmap changed");
  a_bit_set: assert property (clk_en && set_rom_unmap |=> rom_unmap_bit)
    else $error("unmap not set");
  a_ext_first: assert property (v0 && a0[23:22] == 2'h2
    |=> rsp[0].cs == 4'h1 && ext_space_select_pin[0]) else $error("cs2 wrong");
  a_dma_deny: assert property (v1 && req[1].addr[23]
    && (req[1].addr < 24'hFE0000 || rom_unmap_bit)
    |=> rsp[1].target == mmd_pkg::MMD_T_DENY) else $error("dma0 ext");
  a_lcd_deny: assert property (v5 && req[5].addr < 24'h010000
    && req[5].addr >= 24'h0000C0 |=> rsp[5].target == mmd_pkg::MMD_T_DENY)
    else $error("lcd dual ram");
  a_single_stall: assert property (v0 && v1 && a0 >= 24'h010000
    && a0 < 24'h050000 && a0[23:13] == req[1].addr[23:13]
    |=> rsp[0].grant && !rsp[1].grant) else $error("no stall");
  c_rom: cover property (v0 && a0 >= 24'hFE0000);
  c_stall: cover property (v0 && v1 && a0 == req[1].addr);
  c_deny: cover property (v5 && req[5].addr < 24'h010000);
endmodule
bind mmd_decoder mmd_props #(.NUM_M(NUM_M)) mmd_props_i (.clock(clock),
  .resetn(resetn), .clk_en(clk_en), .set_rom_unmap(set_rom_unmap),
  .clr_rom_unmap(clr_rom_unmap), .soft_reset(soft_reset), .req(req),
  .rsp(rsp), .rom_unmap_bit(rom_unmap_bit),
  .ext_space_select_pin(ext_space_select_pin));
`default_nettype wire

// >>> tb/tb.sv
// bench: seven master models drive the decoder, a reference model checks it
// assumes one answer edge after each taken request
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock = 0, resetn = 0, en = 1, su = 0, cu = 0, sr = 0, unmap;
  logic [6:0] go = '0, iob = '0;
  logic [23:0] ad [7] = '{default: '0};
  logic [3:0] pins;
  wire mmd_pkg::mmd_req_t [6:0] req;
  mmd_pkg::mmd_rsp_t [6:0] rsp;
  int err_count = 0, total_checks = 0, m, a, cx, bx;
  bit u = 0;
  for (genvar g = 0; g < 7; g++) begin : mst
    mmd_master_model mmd_master_model_i (.go(go[g]), .io(iob[g]),
      .addr(ad[g]), .req(req[g]));
  end
  mmd_decoder mmd_decoder_i (.clock(clock), .resetn(resetn), .clk_en(en),
    .set_rom_unmap(su), .clr_rom_unmap(cu), .soft_reset(sr), .req(req),
    .rsp(rsp), .rom_unmap_bit(unmap), .ext_space_select_pin(pins));
  initial forever #20 clock = ~clock;
  task conclude();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(logic [31:0] s, logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // reference target code from master, address and unmap state
  function int tgt(int m, int a, bit u);
    if (a < 24'h0000C0) return 8'h02;
    if (a < 24'h010000) return m > 4 ? 8'h80 : 8'h04;
    if (a < 24'h050000) return 8'h08;
    if (a < 24'h800000) return 8'h40;
    if (a >= 24'hFE0000 && !u) return 8'h10;
    return (m > 0 && m < 4) ? 8'h80 : 8'h20;
  endfunction
  // one request from every master in k, same address
  task send(logic [6:0] k, int a, bit io);
    @(posedge clock);
    go <= k;
    iob <= {7{io}};
    ad <= '{default: a[23:0]};
    @(posedge clock);
    go <= '0;
    #1;
  endtask
  task ctl(logic s, logic c, logic r, logic e, logic x);
    @(posedge clock);
    {su, cu, sr, en} <= {s, c, r, e};
    @(posedge clock);
    {su, cu, sr, en} <= 4'h1;
    #1;
    chk(unmap, x);
  endtask
  initial begin
    void'($urandom(95307));
    repeat (10) @(posedge clock);
    resetn <= 1;
    chk(unmap, 0);
    foreach (ad[k]) if (k < 3) begin
      send(7'h01, k == 0 ? 16'h0C00 : k == 1 ? 16'h1800 : 16'h1C00, 1);
      chk(rsp[0].block, k == 0 ? 1 : k == 1 ? 6 : 11);
      chk({rsp[0].grant, rsp[0].target}, 9'h102);
    end
    // dma, lcd and usb on I/O groups
    send(7'h62, 24'h001A00, 1);
    chk({rsp[1].target, rsp[1].block}, {8'h02, 6'h0A});
    chk({rsp[5].target, rsp[6].target}, 16'h8080);
    send(7'h02, 24'h001800, 1);
    chk(rsp[1].target, 8'h80);
    // mapped rom block and first external space
    send(7'h01, 24'hFF8000, 0);
    chk({rsp[0].target, rsp[0].block}, {8'h10, 6'h03});
    send(7'h13, 24'h900000, 0);
    chk({rsp[0].cs, rsp[4].cs, pins}, 12'h111);
    chk(rsp[1].target, 8'h80);
    send(7'h03, 24'h012000, 0);
    chk({rsp[0].grant, rsp[1].grant}, 2'h2);
    send(7'h03, 24'h002000, 0);
    chk({rsp[0].grant, rsp[1].grant}, 2'h3);
    for (int i = 0; i < 400; i++) begin
      if (i == 200) begin
        ctl(1, 0, 0, 1, 1);
        ctl(0, 0, 1, 1, 1);
        u = 1;
      end
      m = $urandom % 7;
      a = ($urandom & 32'hFFFFFF) >> ($urandom % 12);
      send(7'h01 << m, a, 0);
      cx = tgt(m, a, u) != 8'h20 ? 0 : a >= 24'hF00000 ? 8 :
           a >= 24'hE00000 ? 4 : a >= 24'hC00000 ? 2 : 1;
      bx = a < 24'h0000C0 ? 0 : a < 24'h010000 ? a >> 13 :
           a < 24'h050000 ? (a - 24'h010000) >> 13 :
           (a >= 24'hFE0000 && !u) ? (a - 24'hFE0000) >> 15 : 0;
      chk({rsp[m].grant, rsp[m].target},
          9'h100 | tgt(m, a, u));
      chk(rsp[m].block, bx);
      chk({rsp[m].cs, pins}, {cx[3:0], cx[3:0]});
    end
    ctl(0, 1, 0, 0, 1);
    ctl(0, 1, 0, 1, 0);
    ctl(1, 0, 0, 1, 1);
    send(7'h01, 24'hFE0000, 0);
    chk({rsp[0].target, rsp[0].cs, pins}, {8'h20, 4'h8, 4'h8});
    @(posedge clock) resetn <= 0;
    @(posedge clock) resetn <= 1;
    #1 chk(unmap, 0);
    conclude();
  end
  initial begin
    #1000000 err_count++;
    conclude();
  end
endmodule
`default_nettype wire
